// [hw/dcc_map.vh]
// Constants of the disk command channel: decode fields, codes, layouts.
`ifndef DCC_MAP_VH
`define DCC_MAP_VH
`define DCC_CLASS_HI 23
`define DCC_CLASS_LO 18
`define DCC_CLASS_CODE 6'o25
`define DCC_OP_HI 14
`define DCC_OP_LO 12
`define DCC_DEV_HI 11
`define DCC_DEV_LO 6
`define DCC_OP_ACT 3'h1
`define DCC_OP_RTZ 3'h2
`define DCC_OP_ABT 3'h3
`define DCC_OP_XFER 3'h4
`define DCC_OP_RSTAT 3'h5
`define DCC_CW1_WRITE 23
`define DCC_CW1_UNIT_HI 17
`define DCC_CW1_UNIT_LO 16
`define DCC_CW1_CYL_HI 15
`define DCC_CW1_CYL_LO 8
`define DCC_CW1_HEAD_HI 7
`define DCC_CW1_HEAD_LO 4
`define DCC_CW1_SEC_HI 3
`define DCC_CW1_SEC_LO 0
`define DCC_CW2_CNT_HI 13
`define DCC_STAT_W 10
`define DCC_MAX_SECTOR 4'hf
`define DCC_DEV_ADDR_RST 6'h10
`define DCC_PTR_ADDR_RST 15'h0000
`endif

// [hw/dcc_channel.v]
// Disk command channel: instruction decode, control word fetch, sequencer.
//
// The register offsets and the address-and-strobe port were decided locally.
`include "dcc_map.vh"
module dcc_channel #(
   parameter AW = 15,
   parameter DW = 24
) (
   input wire i_clk_sys,
   input wire i_reset_n,
   // Instruction strobe from the host
   input wire i_instr_valid,
   input wire [DW-1:0] i_instr,
   // Core memory port
   output reg o_mem_rd,
   output reg o_mem_wr,
   output reg [AW-1:0] o_mem_addr,
   output reg [DW-1:0] o_mem_wdata,
   input wire i_mem_ack,
   input wire [DW-1:0] i_mem_rdata,
   // Disk side
   output reg o_seek,
   output reg o_rtz,
   output reg o_clr_seek_err,
   output reg [1:0] o_unit,
   output reg [7:0] o_cyl,
   output reg [3:0] o_head,
   output reg [3:0] o_sector,
   output reg o_write,
   output reg o_header_write,
   input wire i_seek_done,
   input wire i_sector_match,
   input wire i_sector_end,
   input wire i_word_strobe,
   input wire [DW-1:0] i_disk_rdata,
   output reg [DW-1:0] o_disk_wdata,
   output reg o_xfer_active,
   input wire [`DCC_STAT_W-1:0] i_err_set,
   input wire i_header_sel,
   // Host status lines
   output reg o_busy,
   output reg o_error,
   // Software register port
   input wire [1:0] i_reg_addr,
   input wire [DW-1:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire i_reg_rd,
   output reg [DW-1:0] o_reg_rdata
);
   // ****************************************
   // Registers and state codes
   // ****************************************
   localparam ST_IDLE = 4'h0;
   localparam ST_PTR = 4'h1;
   localparam ST_CW1 = 4'h2;
   localparam ST_CW2 = 4'h3;
   localparam ST_CW3 = 4'h4;
   localparam ST_SEEK = 4'h5;
   localparam ST_SECT = 4'h6;
   localparam ST_XFER = 4'h7;
   localparam ST_MEMW = 4'h8;
   localparam ST_NEXTC = 4'h9;
   localparam ST_STAT = 4'ha;
   localparam ST_FILL = 4'hb;

   reg [3:0] state_q;
   reg [AW-1:0] car_q;
   reg [13:0] count_q;
   reg abort_q;
   reg [`DCC_STAT_W-1:0] status_q;
   reg [5:0] dev_addr_q;
   reg [AW-1:0] ptr_addr_q;

   // ****************************************
   // Instruction decode; bits 5 to 0 never matter
   // ****************************************
   wire cmd_hit = i_instr_valid &&
      (i_instr[`DCC_CLASS_HI:`DCC_CLASS_LO] == `DCC_CLASS_CODE) &&
      (i_instr[`DCC_DEV_HI:`DCC_DEV_LO] == dev_addr_q);
   wire [2:0] op = i_instr[`DCC_OP_HI:`DCC_OP_LO];
   wire idle = (state_q == ST_IDLE);
   wire err_now = |status_q;
   wire cw_ack = i_mem_ack && o_mem_rd;

   // ****************************************
   // Software registers: device address, pointer address, status
   // ****************************************
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         dev_addr_q <= `DCC_DEV_ADDR_RST;
         ptr_addr_q <= `DCC_PTR_ADDR_RST;
         o_reg_rdata <= 24'h000000;
      end else begin
         if (i_reg_wr && i_reg_addr == 2'h0) begin
            dev_addr_q <= i_reg_wdata[5:0];
         end
         if (i_reg_wr && i_reg_addr == 2'h1) begin
            ptr_addr_q <= i_reg_wdata[AW-1:0];
         end
         // Data stand only in the cycle after the read strobe
         o_reg_rdata <= 24'h000000;
         if (i_reg_rd) begin
            case (i_reg_addr)
               2'h0: o_reg_rdata <= {18'h00000, dev_addr_q};
               2'h1: o_reg_rdata <= {{(DW-AW){1'b0}}, ptr_addr_q};
               2'h2: o_reg_rdata <= {14'h0000, status_q};
               2'h3: o_reg_rdata <= {state_q, 6'h00, count_q};
               default: o_reg_rdata <= 24'h000000;
            endcase
         end
      end
   end

   // ****************************************
   // Command sequencer
   // ****************************************
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_q <= ST_IDLE;
         car_q <= 15'h0000;
         count_q <= 14'h0000;
         abort_q <= 1'b0;
         status_q <= 10'h000;
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
         o_mem_addr <= 15'h0000;
         o_mem_wdata <= 24'h000000;
         o_seek <= 1'b0;
         o_rtz <= 1'b0;
         o_clr_seek_err <= 1'b0;
         o_unit <= 2'h0;
         o_cyl <= 8'h00;
         o_head <= 4'h0;
         o_sector <= 4'h0;
         o_write <= 1'b0;
         o_header_write <= 1'b0;
         o_disk_wdata <= 24'h000000;
         o_xfer_active <= 1'b0;
         o_busy <= 1'b0;
         o_error <= 1'b0;
      end else begin
         o_seek <= 1'b0;
         o_rtz <= 1'b0;
         o_clr_seek_err <= 1'b0;
         o_mem_wr <= 1'b0;
         // Errors accumulate; the transfer clear below loses to a new error
         status_q <= status_q | i_err_set;
         o_error <= |(status_q | i_err_set);
         if (cmd_hit) begin
            case (op)
               `DCC_OP_ACT: begin
                  // A busy line raised by an earlier activate stays set
                  if (!o_busy) begin
                     o_busy <= 1'b1;
                  end
               end
               `DCC_OP_RTZ: begin
                  if (idle) begin
                     o_rtz <= 1'b1;
                     o_clr_seek_err <= 1'b1;
                     o_cyl <= 8'h00;
                  end
               end
               `DCC_OP_ABT: begin
                  // An idle abort leaves nothing behind
                  if (!idle) begin
                     abort_q <= 1'b1;
                     if (state_q == ST_SEEK) begin
                        o_busy <= 1'b0;
                     end
                  end
               end
               `DCC_OP_XFER: begin
                  if (idle) begin
                     status_q <= i_err_set;
                     car_q <= ptr_addr_q;
                     o_mem_addr <= ptr_addr_q;
                     o_mem_rd <= 1'b1;
                     o_busy <= 1'b1;
                     abort_q <= 1'b0;
                     state_q <= ST_PTR;
                  end
               end
               `DCC_OP_RSTAT: begin
                  if (idle) begin
                     o_mem_addr <= ptr_addr_q;
                     o_mem_rd <= 1'b1;
                     o_busy <= 1'b1;
                     state_q <= ST_STAT;
                  end
               end
               default: begin
               end
            endcase
         end
         case (state_q)
            ST_PTR: begin
               if (cw_ack) begin
                  car_q <= i_mem_rdata[AW-1:0];
                  o_mem_addr <= i_mem_rdata[AW-1:0];
                  state_q <= ST_CW1;
               end
            end
            ST_CW1: begin
               if (cw_ack) begin
                  o_write <= i_mem_rdata[`DCC_CW1_WRITE];
                  o_header_write <= i_mem_rdata[`DCC_CW1_WRITE] &&
                     i_header_sel;
                  o_unit <= i_mem_rdata[`DCC_CW1_UNIT_HI:`DCC_CW1_UNIT_LO];
                  o_cyl <= i_mem_rdata[`DCC_CW1_CYL_HI:`DCC_CW1_CYL_LO];
                  o_head <= i_mem_rdata[`DCC_CW1_HEAD_HI:`DCC_CW1_HEAD_LO];
                  o_sector <=
                     i_mem_rdata[`DCC_CW1_SEC_HI:`DCC_CW1_SEC_LO];
                  car_q <= car_q + 15'h0001;
                  o_mem_addr <= car_q + 15'h0001;
                  state_q <= ST_CW2;
               end
            end
            ST_CW2: begin
               if (cw_ack) begin
                  count_q <= i_mem_rdata[`DCC_CW2_CNT_HI:0];
                  car_q <= car_q + 15'h0001;
                  o_mem_addr <= car_q + 15'h0001;
                  state_q <= ST_CW3;
               end
            end
            ST_CW3: begin
               if (cw_ack) begin
                  car_q <= i_mem_rdata[AW-1:0];
                  o_mem_rd <= 1'b0;
                  o_seek <= 1'b1;
                  // Seek overlap: the disk finishes the seek alone
                  if (count_q == 14'h0000) begin
                     o_busy <= 1'b0;
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= ST_SEEK;
                  end
               end
            end
            ST_SEEK: begin
               if (err_now) begin
                  o_busy <= 1'b0;
                  state_q <= ST_IDLE;
               end else if (i_seek_done) begin
                  if (abort_q) begin
                     o_busy <= 1'b0;
                     state_q <= ST_IDLE;
                  end else begin
                     state_q <= ST_SECT;
                  end
               end
            end
            ST_SECT: begin
               if (err_now || abort_q) begin
                  o_busy <= 1'b0;
                  state_q <= ST_IDLE;
               end else if (i_sector_match) begin
                  o_xfer_active <= 1'b1;
                  state_q <= o_write ? ST_FILL : ST_XFER;
                  o_mem_addr <= car_q;
                  o_mem_rd <= o_write;
               end
            end
            // Next write word comes from core before the disk asks
            ST_FILL: begin
               if (i_mem_ack) begin
                  o_mem_rd <= 1'b0;
                  o_disk_wdata <= i_mem_rdata;
                  state_q <= ST_XFER;
               end
            end
            ST_XFER: begin
               // Errors end the transfer at once, sector or not
               if (err_now) begin
                  o_xfer_active <= 1'b0;
                  o_busy <= 1'b0;
                  state_q <= ST_IDLE;
               end else if (i_word_strobe) begin
                  car_q <= car_q + 15'h0001;
                  count_q <= count_q - 14'h0001;
                  if (!o_write) begin
                     // One word in flight: core takes it before the next
                     o_mem_addr <= car_q;
                     o_mem_wdata <= i_disk_rdata;
                     o_mem_wr <= 1'b1;
                     state_q <= ST_MEMW;
                  end else if (count_q == 14'h0000) begin
                     o_xfer_active <= 1'b0;
                     o_busy <= 1'b0;
                     state_q <= ST_IDLE;
                  end else begin
                     o_mem_addr <= car_q + 15'h0001;
                     o_mem_rd <= 1'b1;
                     state_q <= ST_FILL;
                  end
               end else if (i_sector_end) begin
                  if (abort_q) begin
                     o_xfer_active <= 1'b0;
                     o_busy <= 1'b0;
                     state_q <= ST_IDLE;
                  end else if (o_sector == `DCC_MAX_SECTOR) begin
                     // Cylinder carry-over restarts at head zero
                     o_xfer_active <= 1'b0;
                     o_cyl <= o_cyl + 8'h01;
                     o_head <= 4'h0;
                     o_sector <= 4'h0;
                     o_seek <= 1'b1;
                     state_q <= ST_NEXTC;
                  end else begin
                     o_sector <= o_sector + 4'h1;
                  end
               end
            end
            ST_MEMW: begin
               if (i_mem_ack) begin
                  // Read side ends once the count was taken from zero
                  state_q <= (count_q == 14'h3fff) ? ST_IDLE : ST_XFER;
                  if (count_q == 14'h3fff) begin
                     o_xfer_active <= 1'b0;
                     o_busy <= 1'b0;
                  end
               end
            end
            // Waiting on the seek to the next cylinder
            ST_NEXTC: begin
               if (err_now || abort_q) begin
                  o_busy <= 1'b0;
                  state_q <= ST_IDLE;
               end else if (i_seek_done) begin
                  state_q <= ST_SECT;
               end
            end
            ST_STAT: begin
               if (cw_ack) begin
                  // Upper pointer bits go back unchanged
                  o_mem_rd <= 1'b0;
                  o_mem_wdata <= {i_mem_rdata[DW-1:`DCC_STAT_W],
                     status_q};
                  o_mem_wr <= 1'b1;
                  state_q <= ST_MEMW;
                  count_q <= 14'h3fff;
               end
            end
            default: begin
            end
         endcase
      end
   end
endmodule

// [test/dcc_host_model.sv]
// Host arithmetic unit and core memory model facing the channel.
module dcc_host_model (
   input wire logic i_clk_sys,
   input wire logic i_reset_n,
   input wire logic [1:0] i_lat,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [14:0] i_addr,
   input wire logic [23:0] i_wdata,
   input wire logic i_busy,
   input wire logic i_error,
   output logic o_ack,
   output logic [23:0] o_rdata,
   output logic [1:0] o_skip_err,
   output logic [1:0] o_skip_rdy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [23:0] mem [0:511];
   logic [1:0] wait_q;
   // ****************************************
   // Skip counts of the two host test commands
   // ****************************************
   assign o_skip_err = i_error ? 2'h1 : 2'h2;
   assign o_skip_rdy = i_busy ? 2'h2 : 2'h1;
   always @(posedge i_clk_sys or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_ack <= 1'b0;
         o_rdata <= 24'h0;
         wait_q <= 2'h0;
      end else begin
         o_ack <= 1'b0;
         // Read data not reloaded is inverted every cycle, so a stale word comes back every second cycle
         o_rdata <= ~o_rdata;
         if (i_wr) begin
            mem[i_addr[8:0]] <= i_wdata;
            o_ack <= 1'b1;
         end else if (i_rd && !o_ack) begin
            wait_q <= wait_q + 2'h1;
            if (wait_q == i_lat) begin
               o_ack <= 1'b1;
               o_rdata <= mem[i_addr[8:0]];
               wait_q <= 2'h0;
            end
         end
      end
   end
endmodule

// [test/dcc_props.sv]
// Port checker of the disk command channel.
`include "dcc_map.vh"
module dcc_props #(
   parameter AW = 15,
   parameter DW = 24
) (
   input wire i_clk_sys,
   input wire i_reset_n,
   input wire i_instr_valid,
   input wire [DW-1:0] i_instr,
   input wire o_mem_rd,
   input wire o_mem_wr,
   input wire [AW-1:0] o_mem_addr,
   input wire i_mem_ack,
   input wire o_rtz,
   input wire o_clr_seek_err,
   input wire o_write,
   input wire i_word_strobe,
   input wire o_xfer_active,
   input wire [`DCC_STAT_W-1:0] i_err_set,
   input wire o_busy,
   input wire o_error
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_reset_n);
   // ****************************************
   // Command acceptance and sequencing
   // ****************************************
   wire cls = i_instr[23:18] == `DCC_CLASS_CODE;
   wire dev = i_instr[11:6] == `DCC_DEV_ADDR_RST;
   wire hit = i_instr_valid && cls && dev;
   wire [2:0] op = i_instr[14:12];
   property p_start;
      !o_busy && hit && op == `DCC_OP_XFER |=> o_busy && o_mem_rd;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_class;
      i_instr_valid && !cls && !o_busy |=> !o_busy;
   endproperty
   a_class: assert property (p_class) else $error("bad class");
   property p_dev;
      i_instr_valid && !dev && !o_busy |=> !o_busy;
   endproperty
   a_dev: assert property (p_dev) else $error("bad device");
   property p_hold;
      o_mem_rd && !i_mem_ack |=> o_mem_rd && $stable(o_mem_addr);
   endproperty
   a_hold: assert property (p_hold) else $error("read dropped");
   property p_err;
      |i_err_set |-> ##[1:2] o_error;
   endproperty
   a_err: assert property (p_err) else $error("no error line");
   property p_abt;
      !o_busy && hit && op == `DCC_OP_ABT |=> !o_busy;
   endproperty
   a_abt: assert property (p_abt) else $error("idle abort");
   property p_act;
      hit && op == `DCC_OP_ACT |=> o_busy;
   endproperty
   a_act: assert property (p_act) else $error("activate");
   property p_rtz;
      !o_busy && hit && op == `DCC_OP_RTZ |-> ##[1:2] (o_rtz && o_clr_seek_err);
   endproperty
   a_rtz: assert property (p_rtz) else $error("no rtz");
   property p_word;
      o_xfer_active && !o_write && i_word_strobe |-> ##[1:3] o_mem_wr;
   endproperty
   a_word: assert property (p_word) else $error("word lost");
   property p_active;
      o_xfer_active |-> o_busy;
   endproperty
   a_active: assert property (p_active) else $error("idle xfer");
   c_start: cover property (hit && op == `DCC_OP_XFER);
   c_wr: cover property (o_mem_wr);
   c_wxfer: cover property (o_xfer_active && o_write);
endmodule
bind dcc_channel dcc_props #(.AW(AW), .DW(DW)) u_dcc_props (
   .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
   .i_instr_valid(i_instr_valid), .i_instr(i_instr),
   .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr),
   .i_mem_ack(i_mem_ack), .o_rtz(o_rtz), .o_clr_seek_err(o_clr_seek_err),
   .o_write(o_write), .i_word_strobe(i_word_strobe),
   .o_xfer_active(o_xfer_active), .i_err_set(i_err_set),
   .o_busy(o_busy), .o_error(o_error));

// [test/tb_top.sv]
// Self-checking bench of the disk command channel.
`include "dcc_map.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, rst_n = 1'b0, iv = 1'b0, wr = 1'b0, rd = 1'b0;
   logic sdone = 1'b0, smatch = 1'b0, sec_end = 1'b0, wstb = 1'b0;
   logic hsel = 1'b0;
   logic [23:0] ins = 24'h0, drd = 24'h0, wd = 24'h0, rdat, mwd, mrdat, dwd;
   logic [1:0] ra = 2'h0, lat = 2'h0, unit, sk_e, sk_r;
   logic [9:0] eset = 10'h0;
   logic mrd, mwr, ack, seek, rtz, clrse, owr, hwr, act, busy, err;
   logic [14:0] maddr;
   logic [7:0] cyl;
   logic [3:0] head, sec;
   int mismatches = 0, compares = 0, cycles = 0;
   always #20 clk = ~clk;
   dcc_channel u_dcc_channel (.i_clk_sys(clk), .i_reset_n(rst_n),
      .i_instr_valid(iv), .i_instr(ins), .o_mem_rd(mrd), .o_mem_wr(mwr),
      .o_mem_addr(maddr), .o_mem_wdata(mwd), .i_mem_ack(ack),
      .i_mem_rdata(mrdat), .o_seek(seek), .o_rtz(rtz),
      .o_clr_seek_err(clrse), .o_unit(unit), .o_cyl(cyl), .o_head(head),
      .o_sector(sec), .o_write(owr), .o_header_write(hwr),
      .i_seek_done(sdone), .i_sector_match(smatch), .i_sector_end(sec_end),
      .i_word_strobe(wstb), .i_disk_rdata(drd), .o_disk_wdata(dwd),
      .o_xfer_active(act), .i_err_set(eset), .i_header_sel(hsel),
      .o_busy(busy), .o_error(err), .i_reg_addr(ra), .i_reg_wdata(wd),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat));
   dcc_host_model u_dcc_host_model (.i_clk_sys(clk), .i_reset_n(rst_n),
      .i_lat(lat), .i_rd(mrd), .i_wr(mwr), .i_addr(maddr), .i_wdata(mwd),
      .i_busy(busy), .i_error(err), .o_ack(ack), .o_rdata(mrdat),
      .o_skip_err(sk_e), .o_skip_rdy(sk_r));
   // ****************************************
   // Bus, disk and comparison tasks
   // ****************************************
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic pick(input int k);
      case (k)
         0: return seek;
         1: return act;
         2: return busy;
         default: return rtz;
      endcase
   endfunction
   task automatic wait_sig(input int k, input logic v);
      int n;
      n = 0;
      while (pick(k) !== v && n < 300) begin
         cyc(1);
         n++;
      end
      if (n == 300) mismatches++;
   endtask
   function automatic logic [23:0] iw(input logic [2:0] op);
      return {`DCC_CLASS_CODE, 3'h0, op, `DCC_DEV_ADDR_RST, 6'h2a};
   endfunction
   task automatic send(input logic [23:0] w);
      @(posedge clk);
      iv <= 1'b1;
      ins <= w;
      @(posedge clk);
      iv <= 1'b0;
      #1;
   endtask
   task automatic rreg(input logic [1:0] a, input logic [23:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      ra <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdat, exp);
   endtask
   task automatic wreg(input logic [1:0] a, input logic [23:0] d);
      @(posedge clk);
      wr <= 1'b1;
      ra <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic pl(input int k);
      @(posedge clk);
      sdone <= (k == 0);
      sec_end <= (k == 1);
      wstb <= (k == 2);
      @(posedge clk);
      {sdone, sec_end, wstb} <= 3'h0;
      #1;
   endtask
   task automatic xfer(input logic [23:0] w1, input logic [23:0] n);
      u_dcc_host_model.mem[32] = w1;
      u_dcc_host_model.mem[33] = n;
      u_dcc_host_model.mem[34] = 24'h100;
      send(iw(`DCC_OP_XFER));
      wait_sig(0, 1'b1);
   endtask
   task automatic sync_sector;
      pl(0);
      smatch <= 1'b1;
      wait_sig(1, 1'b1);
      smatch <= 1'b0;
   endtask
   task automatic report_and_stop;
      $display("compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         report_and_stop;
      end
   end
   initial begin
      u_dcc_host_model.mem[4] = 24'hc00020;
      u_dcc_host_model.mem[258] = 24'h0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      cyc(1);
      chk(24'({busy, err, seek, mrd, mwr, act}), 24'h0);
      rreg(2'h0, 24'h10);
      wreg(2'h1, 24'h4);
      rreg(2'h1, 24'h4);
      send(iw(`DCC_OP_ACT) ^ 24'h040000);
      send(iw(`DCC_OP_ACT) ^ 24'h000040);
      cyc(2);
      chk(24'(busy), 24'h0);
      xfer(24'h020537, 24'h0);
      chk(24'({owr, unit, cyl, head, sec}), 24'h020537);
      cyc(3);
      chk(24'(busy), 24'h0);
      pl(0);
      // Slow memory on the two-word read
      lat <= 2'h2;
      xfer(24'h020537, 24'h1);
      chk(24'(busy), 24'h1);
      sync_sector;
      drd <= 24'ha5a5a5;
      pl(2);
      cyc(8);
      drd <= 24'h5a0f01;
      pl(2);
      wait_sig(2, 1'b0);
      chk(u_dcc_host_model.mem[256], 24'ha5a5a5);
      chk(u_dcc_host_model.mem[257], 24'h5a0f01);
      chk(u_dcc_host_model.mem[258], 24'h0);
      // Sector fifteen forces a carry into the next cylinder
      xfer(24'h02053f, 24'h1);
      sync_sector;
      pl(1);
      chk(24'({act, cyl, head, sec}), 24'h000600);
      sync_sector;
      drd <= 24'h123456;
      pl(2);
      cyc(4);
      pl(2);
      wait_sig(2, 1'b0);
      chk(u_dcc_host_model.mem[257], 24'h123456);
      u_dcc_host_model.mem[256] = 24'h3c3c3c;
      hsel <= 1'b1;
      xfer(24'h820537, 24'h5);
      sync_sector;
      chk(24'({owr, hwr}), 24'h3);
      send(iw(`DCC_OP_ABT));
      cyc(3);
      chk(24'(busy), 24'h1);
      chk(dwd, 24'h3c3c3c);
      pl(1);
      wait_sig(2, 1'b0);
      chk(24'({busy, act}), 24'h0);
      xfer(24'h020537, 24'h1);
      rreg(2'h3, 24'h500001);
      send(iw(`DCC_OP_ABT));
      cyc(1);
      chk(24'(busy), 24'h0);
      pl(0);
      @(posedge clk);
      eset <= 10'h004;
      @(posedge clk);
      eset <= 10'h0;
      cyc(2);
      chk(24'({err, sk_e}), 24'h5);
      rreg(2'h2, 24'h4);
      send(iw(`DCC_OP_RSTAT));
      cyc(1);
      wait_sig(2, 1'b0);
      chk(u_dcc_host_model.mem[4], 24'hc00004);
      u_dcc_host_model.mem[4] = 24'hc00020;
      xfer(24'h020537, 24'h0);
      rreg(2'h2, 24'h0);
      chk(24'(err), 24'h0);
      pl(0);
      send(iw(`DCC_OP_ABT));
      cyc(1);
      chk(24'(busy), 24'h0);
      send(iw(`DCC_OP_RTZ));
      wait_sig(3, 1'b1);
      chk(24'({clrse, cyl}), 24'h100);
      send(iw(`DCC_OP_ACT));
      cyc(1);
      chk(24'({busy, sk_r}), 24'h6);
      send(iw(`DCC_OP_ACT));
      cyc(1);
      chk(24'(busy), 24'h1);
      report_and_stop;
   end
endmodule
